// ===== rtl/mom_map.svh
// Constants of the mains override and mode control block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package and the top module.
`ifndef MOM_MAP_SVH
`define MOM_MAP_SVH

`define MOM_NIN 8
`define MOM_NSET 3
// Register byte offsets on the Wishbone slave.
`define MOM_ADR_CTRL 8'h00
`define MOM_ADR_FLASH 8'h04
`define MOM_ADR_INCFG 8'h08
`define MOM_ADR_LIMIT 8'h28
`define MOM_ADR_STATUS 8'h40
// Control register fields.
`define MOM_CTRL_DSIM 0
`define MOM_CTRL_SPH 1
`define MOM_CTRL_LOCK 2
// Reset values.
`define MOM_CTRL_RST 3'h0
`define MOM_FLASH_RST 16'h0000
`define MOM_INCFG_RST 8'h00
`define MOM_LIMIT_RST 32'h00000000
// Alarm input_alarm_code_a code that silences an input.
`define MOM_ALARM_NONE 2'h3
// Timing: clock rate, base tick in milliseconds, minutes and hours.
`define MOM_CLK_HZ 125000000
`define MOM_TICK_MS 1000
`define MOM_SEC_CYCLES (`MOM_CLK_HZ / 1000 * `MOM_TICK_MS)
`define MOM_SEC_PER_MIN 60
`define MOM_MIN_PER_HOUR 14'h003C
`define MOM_ZERO_HOUR_MIN 14'h0002

`endif

// ===== rtl/mom_pkg.sv
// Types shared by the mains override and mode control block.
// Assumes the constant header is on the include path.
`include "mom_map.svh"

package mom_pkg;

  typedef logic [13:0] mom_min_t;

  // Input function codes held in each input configuration word.
  typedef enum logic [3:0] {
    FN_NONE = 4'h0, FN_RSTART = 4'h1, FN_DAS = 4'h2, FN_SIM = 4'h3,
    FN_PRIO = 4'h4, FN_VF2 = 4'h5, FN_VF3 = 4'h6, FN_FSTOP = 4'h7,
    FN_FAUTO = 4'h8, FN_FTEST = 4'h9, FN_FSTART = 4'hA, FN_FRESET = 4'hB,
    FN_MUTE = 4'hC, FN_LOCK = 4'hD
  } mom_func_e;

  typedef struct packed {
    logic [1:0] alarm_code;
    logic neg;
    logic nc;
    mom_func_e func;
  } mom_incfg_s;

  typedef enum logic [3:0] {
    MODE_STOP = 4'h1, MODE_AUTO = 4'h2, MODE_MANUAL = 4'h4, MODE_TEST = 4'h8
  } mom_mode_e;

  typedef enum logic [2:0] {
    SIM_IDLE = 3'h1, SIM_HOLD = 3'h2, SIM_ACTIVE = 3'h4
  } mom_sim_e;

endpackage : mom_pkg

// ===== rtl/mom_tmr_if.sv
// Handshake between the control logic and a minute-resolution timer.
// Assumes both ends share clk_i.
interface mom_tmr_if;
  import mom_pkg::*;
  logic start;
  mom_min_t load_min;
  logic busy;
  logic done;
  modport ctl (output start, output load_min, input busy, input done);
  modport tmr (input start, input load_min, output busy, output done);
endinterface : mom_tmr_if

// ===== rtl/mom_min_timer.sv
// Minute-resolution down counter, loaded on start, done pulse at expiry.
// Assumes a one-cycle minute tick; the first minute may be short by up to one tick.
module mom_min_timer
  import mom_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic min_tick_i,
  mom_tmr_if.tmr tif
);
  mom_min_t cnt_ff;
  logic busy_ff;
  logic done_ff;

  // Load, count down on minute ticks, and flag the expiry for one cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_ff <= 14'h0000;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      if (tif.start && !busy_ff)
      begin
        cnt_ff <= tif.load_min;
        busy_ff <= 1'b1;
      end
      else if (busy_ff && min_tick_i)
      begin
        if (cnt_ff <= 14'h0001)
        begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
        else
        begin
          cnt_ff <= cnt_ff - 14'h0001;
        end
      end
    end
  end

  assign tif.busy = busy_ff;
  assign tif.done = done_ff;
endmodule : mom_min_timer

// ===== rtl/mom_in_cond.sv
// One function input: pin synchroniser and contact-type conversion to a logical level.
// Assumes the pin is asynchronous to clk_i.
module mom_in_cond
  import mom_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic nc_i,
  input wire logic neg_i,
  output logic active_o
);
  logic s1_ff;
  logic s2_ff;
  logic act_ff;

  // Two flops against metastability, then the contact mapping.
  // A contact to battery negative pulls the pin low when closed; a closed NC contact is idle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      act_ff <= 1'b0;
    end
    else
    begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      act_ff <= s2_ff ^ neg_i ^ nc_i;
    end
  end

  assign active_o = act_ff;
endmodule : mom_in_cond

// ===== rtl/mom_ctrl.sv
// Mains override and mode control: function inputs, mains override, flashing relay,
// limit-set selection, topology masks and operating mode, with a Wishbone slave.
// Assumes measured mains and engine state come from logic on clk_i; pins and buttons do not.
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`include "mom_map.svh"

module mom_ctrl
  import mom_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `MOM_SEC_CYCLES
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic stb_i,
  input wire logic cyc_i,
  output logic ack_o,
  input wire logic [`MOM_NIN-1:0] in_pin_i,
  input wire logic btn_stop_i,
  input wire logic btn_auto_i,
  input wire logic btn_run_i,
  input wire logic btn_test_i,
  input wire logic mains_ok_i,
  input wire logic engine_running_i,
  input wire logic gen_on_load_i,
  output logic mains_ok_eff_o,
  output logic mains_led_o,
  output logic start_req_o,
  output logic master_o,
  output logic flash_relay_o,
  output logic [3:0] mode_o,
  output logic [1:0] limit_sel_o,
  output logic [15:0] nom_volt_o,
  output logic [15:0] nom_freq_o,
  output logic [15:0] nom_rpm_o,
  output logic [15:0] oc_limit_o,
  output logic [2:0] phase_en_o,
  output logic disp_l23_en_o,
  output logic disp_ll_en_o,
  output logic [`MOM_NIN-1:0] input_alarm_o,
  output logic fault_reset_o,
  output logic alarm_mute_o,
  output logic panel_locked_o
);

  // Register file.
  logic [2:0] ctrl_ff;
  logic [15:0] flash_cfg_ff;
  mom_incfg_s incfg_ff [`MOM_NIN];
  logic [31:0] limit_ff [2*`MOM_NSET];
  logic ack_ff;
  logic [31:0] rd_ff;
  logic [31:0] nxt_rd;

  // Function decode results: in_act indexed by input, fn_act and fn_asg indexed by function code.
  logic [`MOM_NIN-1:0] in_act;
  logic [15:0] fn_act;
  logic [15:0] fn_asg;

  // Time base and timers.
  logic [26:0] sec_cnt_ff;
  logic [5:0] min_sec_ff;
  logic min_tick_ff;
  logic flash_ff;
  mom_min_t on_min;
  mom_min_t off_min;
  mom_sim_e sim_ff;
  logic sim_prev_ff;

  // Mode and panel.
  logic [3:0] btn_s1_ff;
  logic [3:0] btn_s2_ff;
  logic [3:0] btn_s3_ff;
  logic [3:0] btn_rise;
  mom_mode_e btn_mode_ff;
  mom_mode_e nxt_mode;
  logic forced;
  logic locked;
  logic fres_prev_ff;
  logic mains_ok_eff;
  logic [1:0] nxt_sel;

  mom_tmr_if flash_tif ();
  mom_tmr_if hold_tif ();

  // Zero hours is stretched to a short period so that the alternation can be tested.
  function automatic mom_min_t hours_to_min(input logic [7:0] h);
    mom_min_t m;
    m = mom_min_t'({6'h00, h}) * `MOM_MIN_PER_HOUR;
    if (h == 8'h00)
      m = `MOM_ZERO_HOUR_MIN;
    return m;
  endfunction : hours_to_min

  // Merge a write into a word under the byte enables.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        r[8*b +: 8] = wd[8*b +: 8];
    return r;
  endfunction : merge

  // Wishbone classic: ack one cycle after the request, dropped the cycle after.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      rd_ff <= 32'h00000000;
    end
    else
    begin
      ack_ff <= cyc_i && stb_i && !ack_ff;
      if (cyc_i && stb_i && !ack_ff)
        rd_ff <= nxt_rd;
    end
  end

  // Writes land on the edge where the master sees ack; unmapped offsets are ignored.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_ff <= `MOM_CTRL_RST;
      flash_cfg_ff <= `MOM_FLASH_RST;
      for (int i = 0; i < `MOM_NIN; i++)
        incfg_ff[i] <= `MOM_INCFG_RST;
      for (int j = 0; j < 2*`MOM_NSET; j++)
        limit_ff[j] <= `MOM_LIMIT_RST;
    end
    else if (cyc_i && stb_i && we_i && ack_ff)
    begin
      if (adr_i == `MOM_ADR_CTRL)
        ctrl_ff <= 3'(merge({29'h00000000, ctrl_ff}, dat_i, sel_i));
      if (adr_i == `MOM_ADR_FLASH)
        flash_cfg_ff <= 16'(merge({16'h0000, flash_cfg_ff}, dat_i, sel_i));
      for (int i = 0; i < `MOM_NIN; i++)
        if (adr_i == `MOM_ADR_INCFG + 8'(4*i))
          incfg_ff[i] <= mom_incfg_s'(8'(merge({24'h000000, incfg_ff[i]}, dat_i, sel_i)));
      for (int j = 0; j < 2*`MOM_NSET; j++)
        if (adr_i == `MOM_ADR_LIMIT + 8'(4*j))
          limit_ff[j] <= merge(limit_ff[j], dat_i, sel_i);
    end
  end

  // Read mux; unmapped offsets read as zero.
  always_comb
  begin
    nxt_rd = 32'h00000000;
    if (adr_i == `MOM_ADR_CTRL)
      nxt_rd = {29'h00000000, ctrl_ff};
    if (adr_i == `MOM_ADR_FLASH)
      nxt_rd = {16'h0000, flash_cfg_ff};
    for (int i = 0; i < `MOM_NIN; i++)
      if (adr_i == `MOM_ADR_INCFG + 8'(4*i))
        nxt_rd = {24'h000000, incfg_ff[i]};
    for (int j = 0; j < 2*`MOM_NSET; j++)
      if (adr_i == `MOM_ADR_LIMIT + 8'(4*j))
        nxt_rd = limit_ff[j];
    if (adr_i == `MOM_ADR_STATUS)
      nxt_rd = {11'h000, in_act, 1'b0, sim_ff, flash_ff, limit_sel_o, master_o,
                mains_ok_eff_o, mode_o};
  end

  assign ack_o = ack_ff;
  assign dat_o = rd_ff;

  for (genvar g = 0; g < `MOM_NIN; g++)
  begin : g_in
    mom_in_cond u_cond (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(in_pin_i[g]),
      .nc_i(incfg_ff[g].nc),
      .neg_i(incfg_ff[g].neg),
      .active_o(in_act[g])
    );
  end

  always_comb
  begin
    fn_act = 16'h0000;
    fn_asg = 16'h0000;
    for (int i = 0; i < `MOM_NIN; i++)
    begin
      fn_asg[incfg_ff[i].func] = 1'b1;
      if (in_act[i])
        fn_act[incfg_ff[i].func] = 1'b1;
    end
  end

  // Second and minute ticks; the whole flashing timing rests on this single divider.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sec_cnt_ff <= 27'h0000000;
      min_sec_ff <= 6'h00;
      min_tick_ff <= 1'b0;
    end
    else
    begin
      min_tick_ff <= 1'b0;
      if (sec_cnt_ff == 27'(SEC_CYCLES - 1))
      begin
        sec_cnt_ff <= 27'h0000000;
        if (min_sec_ff == 6'(`MOM_SEC_PER_MIN - 1))
        begin
          min_sec_ff <= 6'h00;
          min_tick_ff <= 1'b1;
        end
        else
          min_sec_ff <= min_sec_ff + 6'h01;
      end
      else
        sec_cnt_ff <= sec_cnt_ff + 27'h0000001;
    end
  end

  assign on_min = hours_to_min(flash_cfg_ff[7:0]);
  assign off_min = hours_to_min(flash_cfg_ff[15:8]);

  assign flash_tif.start = !flash_tif.busy && !flash_tif.done;
  assign flash_tif.load_min = flash_ff ? on_min : off_min;

  mom_min_timer u_flash_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .min_tick_i(min_tick_ff),
    .tif(flash_tif)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flash_ff <= 1'b0;
    else if (flash_tif.done)
      flash_ff <= !flash_ff;
  end

  assign hold_tif.start = (sim_ff == SIM_IDLE) && fn_act[FN_SIM] && !sim_prev_ff
                          && gen_on_load_i;
  assign hold_tif.load_min = on_min;

  mom_min_timer u_hold_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .min_tick_i(min_tick_ff),
    .tif(hold_tif)
  );

  // Delayed mains simulation state; an early removal simply abandons the hold-off.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sim_ff <= SIM_IDLE;
      sim_prev_ff <= 1'b0;
    end
    else
    begin
      sim_prev_ff <= fn_act[FN_SIM];
      case (sim_ff)
        SIM_IDLE:
          if (fn_act[FN_SIM])
            sim_ff <= gen_on_load_i ? SIM_HOLD : SIM_ACTIVE;
        SIM_HOLD:
          if (!fn_act[FN_SIM])
            sim_ff <= SIM_IDLE;
          else if (hold_tif.done)
            sim_ff <= SIM_ACTIVE;
        SIM_ACTIVE:
          if (!fn_act[FN_SIM])
            sim_ff <= SIM_IDLE;
        default:
          sim_ff <= SIM_IDLE;
      endcase
    end
  end

  // Effective mains status seen by the start and cooldown sequencers.
  always_comb
  begin
    if (fn_asg[FN_RSTART])
      mains_ok_eff = !fn_act[FN_RSTART];
    else if (fn_act[FN_DAS])
      mains_ok_eff = 1'b1;
    else if (ctrl_ff[`MOM_CTRL_DSIM] && (sim_ff == SIM_ACTIVE))
      mains_ok_eff = 1'b1;
    else
      mains_ok_eff = mains_ok_i;
  end

  // Button pins pass two flops; the third only feeds the edge detector.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      btn_s1_ff <= 4'h0;
      btn_s2_ff <= 4'h0;
      btn_s3_ff <= 4'h0;
    end
    else
    begin
      btn_s1_ff <= {btn_test_i, btn_run_i, btn_auto_i, btn_stop_i};
      btn_s2_ff <= btn_s1_ff;
      btn_s3_ff <= btn_s2_ff;
    end
  end

  assign btn_rise = btn_s2_ff & ~btn_s3_ff;
  assign locked = fn_act[FN_LOCK] || ctrl_ff[`MOM_CTRL_LOCK];
  assign forced = fn_act[FN_FSTOP] || fn_act[FN_FTEST] || fn_act[FN_FAUTO];

  // Last mode chosen by pushbutton, frozen while forced or locked.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      btn_mode_ff <= MODE_STOP;
    else if (!forced && !locked)
    begin
      if (btn_rise[0])
        btn_mode_ff <= MODE_STOP;
      else if (btn_rise[1])
        btn_mode_ff <= MODE_AUTO;
      else if (btn_rise[2])
        btn_mode_ff <= MODE_MANUAL;
      else if (btn_rise[3])
        btn_mode_ff <= MODE_TEST;
    end
  end

  always_comb
  begin
    if (fn_act[FN_FSTOP])
      nxt_mode = MODE_STOP;
    else if (fn_act[FN_FTEST])
      nxt_mode = MODE_TEST;
    else if (fn_act[FN_FAUTO])
      nxt_mode = MODE_AUTO;
    else
      nxt_mode = btn_mode_ff;
  end

  assign nxt_sel = fn_act[FN_VF3] ? 2'h2 : (fn_act[FN_VF2] ? 2'h1 : 2'h0);

  // Registered outputs; every decision reaches the pins one cycle after its cause.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mains_ok_eff_o <= 1'b0;
      mains_led_o <= 1'b0;
      start_req_o <= 1'b0;
      master_o <= 1'b0;
      flash_relay_o <= 1'b0;
      mode_o <= MODE_STOP;
      limit_sel_o <= 2'h0;
      nom_volt_o <= 16'h0000;
      nom_freq_o <= 16'h0000;
      nom_rpm_o <= 16'h0000;
      oc_limit_o <= 16'h0000;
      phase_en_o <= 3'h7;
      disp_l23_en_o <= 1'b1;
      disp_ll_en_o <= 1'b1;
      input_alarm_o <= 8'h00;
      fault_reset_o <= 1'b0;
      alarm_mute_o <= 1'b0;
      panel_locked_o <= 1'b0;
      fres_prev_ff <= 1'b0;
    end
    else
    begin
      mains_ok_eff_o <= mains_ok_eff;
      mains_led_o <= mains_ok_eff;
      master_o <= !fn_asg[FN_PRIO] || fn_act[FN_PRIO];
      start_req_o <= (nxt_mode == MODE_AUTO) &&
                     ((!mains_ok_eff && (!fn_asg[FN_PRIO] || fn_act[FN_PRIO])) ||
                      (fn_act[FN_FSTART] && !fn_asg[FN_RSTART] && !fn_act[FN_DAS]));
      flash_relay_o <= flash_ff;
      mode_o <= nxt_mode;
      limit_sel_o <= nxt_sel;
      nom_volt_o <= limit_ff[2*nxt_sel][31:16];
      nom_freq_o <= limit_ff[2*nxt_sel][15:0];
      nom_rpm_o <= limit_ff[2*nxt_sel+1][31:16];
      oc_limit_o <= limit_ff[2*nxt_sel+1][15:0];
      phase_en_o <= ctrl_ff[`MOM_CTRL_SPH] ? 3'h1 : 3'h7;
      disp_l23_en_o <= !ctrl_ff[`MOM_CTRL_SPH];
      disp_ll_en_o <= !ctrl_ff[`MOM_CTRL_SPH];
      for (int i = 0; i < `MOM_NIN; i++)
        input_alarm_o[i] <= in_act[i] && (incfg_ff[i].alarm_code != `MOM_ALARM_NONE);
      fres_prev_ff <= fn_act[FN_FRESET];
      fault_reset_o <= fn_act[FN_FRESET] && !fres_prev_ff;
      alarm_mute_o <= fn_act[FN_MUTE];
      panel_locked_o <= locked;
    end
  end

endmodule : mom_ctrl

// ===== sim/mom_ctrl_props.sv
// Checker for the mains override block, bound to every mom_ctrl instance.
// Assumes a Wishbone master that waits for ack and then drops cyc and stb.
module mom_ctrl_props
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic mains_ok_eff_o,
  input wire logic mains_led_o,
  input wire logic fault_reset_o,
  input wire logic [3:0] mode_o,
  input wire logic [1:0] limit_sel_o,
  input wire logic [2:0] phase_en_o,
  input wire logic disp_l23_en_o,
  input wire logic disp_ll_en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, so clocking and reset are stated once.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A fresh bus request, and its answer of exactly one cycle.
  sequence wb_req_s;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence wb_ack_s;
    ack_o ##1 !ack_o;
  endsequence
  wb_answer_a: assert property (wb_req_s |=> wb_ack_s)
    else $error("bus request not answered by a single ack");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  led_mirror_a: assert property (mains_led_o == mains_ok_eff_o)
    else $error("mains lamp differs from effective mains");
  mode_onehot_a: assert property ($onehot(mode_o))
    else $error("mode is not one-hot");
  sph_mask_a: assert property (phase_en_o == 3'h1 |-> !disp_l23_en_o && !disp_ll_en_o)
    else $error("single phase still shows other phases");
  phase_set_a: assert property (phase_en_o == 3'h7 || phase_en_o == 3'h1)
    else $error("phase check mask is neither all nor first");
  limit_range_a: assert property (limit_sel_o != 2'h3)
    else $error("limit set selection out of range");
  reset_pulse_a: assert property (fault_reset_o |=> !fault_reset_o)
    else $error("fault reset longer than one cycle");
endmodule : mom_ctrl_props

bind mom_ctrl mom_ctrl_props u_mom_ctrl_props (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o,
  .mains_ok_eff_o, .mains_led_o, .fault_reset_o, .mode_o, .limit_sel_o, .phase_en_o,
  .disp_l23_en_o, .disp_ll_en_o);

// ===== sim/mom_ext_model.sv
// Far side model: wired contacts of the function inputs and the panel buttons.
// Assumes the bench gives logical levels; the contact wiring is fixed per input.
module mom_ext_model
(
  input wire logic [7:0] lvl_i,
  input wire logic [7:0] nc_i,
  input wire logic [7:0] neg_i,
  input wire logic [3:0] press_i,
  output logic [7:0] pin_o,
  output logic [3:0] btn_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // contact wiring
  // NC contacts and minus switching each invert the pin, so both are exercised.
  assign pin_o = lvl_i ^ nc_i ^ neg_i;
  // Buttons are plain contacts; the bench holds a press for several cycles.
  assign btn_o = press_i;
endmodule : mom_ext_model

// ===== sim/mom_ctrl_tb.sv
// Self-checking bench for mom_ctrl: bus tasks, one task per scenario, verdict.
// Assumes 125 MHz and a shortened second of 10 cycles, so a minute is 600 cycles.
module mom_ctrl_tb
  import mom_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
  logic [7:0] adr_i = 8'h00, lvl = 8'h00, nc = 8'h01, neg = 8'h02, in_pin_i;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [3:0] sel_i = 4'hF, press = 4'h0, mode_o;
  logic mains_ok_i = 1'b1, engine_running_i = 1'b0, gen_on_load_i = 1'b0;
  logic btn_stop_i, btn_auto_i, btn_run_i, btn_test_i, ack_o, mains_ok_eff_o;
  logic mains_led_o, start_req_o, master_o, flash_relay_o, fault_reset_o;
  logic alarm_mute_o, panel_locked_o, disp_l23_en_o, disp_ll_en_o;
  logic [1:0] limit_sel_o;
  logic [2:0] phase_en_o;
  logic [7:0] input_alarm_o;
  logic [15:0] nom_volt_o, nom_freq_o, nom_rpm_o, oc_limit_o;
  int bad_count = 0, checks_done = 0;

  mom_ctrl #(.SEC_CYCLES(10)) u_mom_ctrl (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i,
    .sel_i, .stb_i, .cyc_i, .ack_o, .in_pin_i, .btn_stop_i, .btn_auto_i, .btn_run_i,
    .btn_test_i, .mains_ok_i, .engine_running_i, .gen_on_load_i, .mains_ok_eff_o,
    .mains_led_o, .start_req_o, .master_o, .flash_relay_o, .mode_o, .limit_sel_o,
    .nom_volt_o, .nom_freq_o, .nom_rpm_o, .oc_limit_o, .phase_en_o, .disp_l23_en_o,
    .disp_ll_en_o, .input_alarm_o, .fault_reset_o, .alarm_mute_o, .panel_locked_o);
  mom_ext_model u_mom_ext_model (.lvl_i(lvl), .nc_i(nc), .neg_i(neg), .press_i(press),
    .pin_o(in_pin_i), .btn_o({btn_test_i, btn_run_i, btn_auto_i, btn_stop_i}));

  // Free-running 8 ns clock.
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic limit();
    bad_count++;
    print_verdict();
  endtask : limit

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // Classic cycle: hold the request until ack is sampled, then a one-cycle gap.
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    adr_i <= a;
    we_i <= w;
    dat_i <= d;
    sel_i <= 4'hF;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 50)
      limit();
    @(posedge clk_i);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, 1'b1, d, q);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(a, 1'b0, 32'h0, q);
    chk(q, e);
  endtask : rdc

  task automatic cfg(input int i, input logic [3:0] f, input logic [1:0] code);
    wr(8'(8'h08 + 4 * i), {24'h0, code, neg[i], nc[i], f});
  endtask : cfg

  // Pins need three edges to land and one more to reach the outputs; eight is ample.
  task automatic put(input logic [7:0] v);
    lvl <= v;
    tick(8);
  endtask : put

  task automatic btn(input logic [3:0] b);
    press <= b;
    tick(6);
    press <= 4'h0;
    tick(6);
  endtask : btn

  task automatic mains_blip();
    mains_ok_i <= 1'b1;
    tick(4);
    mains_ok_i <= 1'b0;
    tick(6);
  endtask : mains_blip

  task automatic s_reset();
    chk(mode_o, 4'h1);
    chk(phase_en_o, 3'h7);
    wr(8'h80, 32'hFFFFFFFF);
    rdc(8'h80, 32'h0);
    rdc(8'h04, 32'h0);
  endtask : s_reset

  task automatic s_rstart();
    wr(8'h00, 32'h1);
    cfg(0, FN_RSTART, 2'h3);
    cfg(1, FN_DAS, 2'h0);
    mains_ok_i <= 1'b0;
    put(8'h03);
    chk(mains_ok_eff_o, 1'b0);
    chk(mains_led_o, 1'b0);
    chk(input_alarm_o, 8'h02);
    put(8'h02);
    chk(mains_ok_eff_o, 1'b1);
    chk(mains_led_o, 1'b1);
    cfg(0, FN_NONE, 2'h3);
    put(8'h00);
  endtask : s_rstart

  task automatic s_modes();
    btn(4'h4);
    chk(mode_o, 4'h4);
    cfg(5, FN_FSTOP, 2'h3);
    cfg(6, FN_FTEST, 2'h3);
    cfg(7, FN_FAUTO, 2'h3);
    put(8'h80);
    chk(mode_o, 4'h2);
    put(8'hC0);
    chk(mode_o, 4'h8);
    put(8'hE0);
    chk(mode_o, 4'h1);
    btn(4'h8);
    chk(mode_o, 4'h1);
    put(8'h00);
    chk(mode_o, 4'h4);
    btn(4'h2);
    chk(mode_o, 4'h2);
  endtask : s_modes

  task automatic s_das();
    chk(start_req_o, 1'b1);
    put(8'h02);
    chk(mains_ok_eff_o, 1'b1);
    chk(start_req_o, 1'b0);
    put(8'h00);
    chk(mains_ok_eff_o, 1'b0);
  endtask : s_das

  task automatic s_prio();
    cfg(2, FN_PRIO, 2'h3);
    put(8'h04);
    mains_blip();
    chk(master_o, 1'b1);
    chk(start_req_o, 1'b1);
    put(8'h00);
    mains_blip();
    chk(master_o, 1'b0);
    chk(start_req_o, 1'b0);
  endtask : s_prio

  task automatic s_limits();
    wr(8'h30, 32'h01900032);
    wr(8'h34, 32'h05DC0064);
    wr(8'h38, 32'h00E6003C);
    wr(8'h3C, 32'h070800C8);
    cfg(3, FN_VF2, 2'h3);
    cfg(4, FN_VF3, 2'h3);
    put(8'h08);
    chk({nom_volt_o, nom_freq_o}, 32'h01900032);
    chk({nom_rpm_o, oc_limit_o}, 32'h05DC0064);
    chk(limit_sel_o, 2'h1);
    put(8'h10);
    chk({nom_volt_o, nom_freq_o}, 32'h00E6003C);
    chk({nom_rpm_o, oc_limit_o}, 32'h070800C8);
    chk(limit_sel_o, 2'h2);
    put(8'h00);
    chk(limit_sel_o, 2'h0);
  endtask : s_limits

  task automatic s_panel();
    logic [31:0] n;
    wr(8'h00, 32'h3);
    tick(3);
    chk({phase_en_o, disp_l23_en_o, disp_ll_en_o}, 5'h04);
    wr(8'h00, 32'h5);
    tick(3);
    chk(panel_locked_o, 1'b1);
    btn(4'h1);
    chk(mode_o, 4'h2);
    wr(8'h00, 32'h1);
    cfg(0, FN_FRESET, 2'h3);
    n = 0;
    lvl <= 8'h01;
    repeat (12)
    begin
      @(posedge clk_i);
      n += fault_reset_o;
    end
    chk(n, 1);
    cfg(0, FN_MUTE, 2'h3);
    tick(4);
    chk(alarm_mute_o, 1'b1);
  endtask : s_panel

  // Delayed simulation on input 2: off load it acts at once, on load after the on-time.
  task automatic s_sim();
    cfg(2, FN_SIM, 2'h3);
    put(8'h05);
    chk(mains_ok_eff_o, 1'b1);
    chk(start_req_o, 1'b0);
    put(8'h01);
    chk(mains_ok_eff_o, 1'b0);
    chk(start_req_o, 1'b1);
    cfg(1, FN_RSTART, 2'h3);
    put(8'h07);
    chk(mains_ok_eff_o, 1'b0);
    cfg(1, FN_NONE, 2'h3);
    tick(3);
    chk(mains_ok_eff_o, 1'b1);
    put(8'h01);
    gen_on_load_i <= 1'b1;
    put(8'h05);
    chk(mains_ok_eff_o, 1'b0);
    tick(500);
    chk(mains_ok_eff_o, 1'b0);
    tick(800);
    chk(mains_ok_eff_o, 1'b1);
    gen_on_load_i <= 1'b0;
    put(8'h01);
  endtask : s_sim

  // A zero-hour period is two minutes; the first minute may be two cycles short.
  task automatic flip(output int n);
    logic s;
    s = flash_relay_o;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (flash_relay_o === s && n < 3000);
    if (n >= 3000)
      limit();
  endtask : flip

  task automatic s_flash();
    int n;
    flip(n);
    flip(n);
    chk(n >= 1198 && n <= 1202, 1'b1);
    flip(n);
    chk(n >= 1198 && n <= 1202, 1'b1);
  endtask : s_flash

  // Main sequence: reset for four cycles, then each scenario in turn.
  initial
  begin
    tick(4);
    rst_i <= 1'b0;
    @(posedge clk_i);
    s_reset();
    s_rstart();
    s_modes();
    s_das();
    s_prio();
    s_limits();
    s_panel();
    s_sim();
    s_flash();
    print_verdict();
  end
endmodule : mom_ctrl_tb
